// File: hw/src_pkg.sv
// shared constants and types for the system reset combiner
package src_pkg;

	// ==========================================================
	// clock and settle timing
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned POWERON_SETTLE_NS = 10000;
	localparam int unsigned BROWNOUT_SETTLE_NS = 10000;
	localparam int unsigned POWERUP_SETTLE_NS = 64000;
	// least times, so round up to whole cycles
	localparam int unsigned POWERON_SETTLE_CYC =
		(POWERON_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned BROWNOUT_SETTLE_CYC =
		(BROWNOUT_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned POWERUP_SETTLE_CYC =
		(POWERUP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W = 12;

	// ==========================================================
	// register map
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 16;
	localparam logic [3:0] OFS_CAUSE = 4'h0;
	localparam logic [3:0] OFS_IRQ_STAT = 4'h4;
	localparam logic [3:0] OFS_IRQ_MASK = 4'h8;

	// reset cause bit positions
	localparam int unsigned NUM_CAUSE = 8;
	localparam int unsigned CAUSE_POWERON = 0;
	localparam int unsigned CAUSE_BROWNOUT = 1;
	localparam int unsigned CAUSE_CLEAR_PIN = 2;
	localparam int unsigned CAUSE_SOFTWARE = 3;
	localparam int unsigned CAUSE_WATCHDOG = 4;
	localparam int unsigned CAUSE_CONFIG = 5;
	localparam int unsigned CAUSE_TRAP = 6;
	localparam int unsigned CAUSE_ILLEGAL = 7;

	// reset values
	localparam logic [7:0] CAUSE_POWERON_RST = 8'h01;
	localparam logic [7:0] IRQ_MASK_RST = 8'h00;
	localparam logic [23:0] RESET_VECTOR = 24'h000000;

	// ==========================================================
	// types
	typedef enum logic [2:0]
	{
		SRC_ST_POWERON_WAIT = 3'b000,
		SRC_ST_POWERON_DLY = 3'b001,
		SRC_ST_BROWNOUT_LOW = 3'b010,
		SRC_ST_BROWNOUT_DLY = 3'b011,
		SRC_ST_POWERUP_DLY = 3'b100,
		SRC_ST_RUN = 3'b101
	} src_state_t;

	typedef struct packed
	{
		logic software_instr_reset;
		logic watchdog_timeout_reset;
		logic config_mismatch_reset;
		logic trap_conflict_reset;
		logic illegal_opcode;
		logic uninit_wreg;
		logic security_violation;
	} src_core_req_t;

	typedef struct packed
	{
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} src_bus_req_t;

endpackage : src_pkg

// File: hw/src_reset_combiner.sv
// system reset combiner: source merge, supply sequencing, cause flags
// Operation
// (RULE1) all reset sources merge into one master reset output
// (RULE2) sources: power-on, brown-out, clear pin, software, watchdog, config, trap, illegal
// (RULE3) master reset is active while any source is active
// (RULE4) reset forces selected registers to defaults, others keep contents
// (RULE5) each reset event sets its own cause flag
// (RULE6) power-on clears all cause flags except the power-on flag at bit 0
// (RULE7) software may write any cause flag to one or zero at any time; here a source still active keeps its flag set over the write
// (RULE8) writing a cause flag never causes a reset
// (RULE9) software should clear cause flags after reading them
// (RULE10) power-on reset holds until supply is above threshold plus settle delay
// (RULE11) power-on reset sets cause bit 0
// (RULE12) brown-out reset asserts while supply is below brown-out threshold
// (RULE13) brown-out reset holds until supply recovers plus brown-out settle delay
// (RULE14) brown-out reset sets cause bit 1
// (RULE15) power-up delay runs after the brown-out delay before release
// (RULE16) every supply recovery restarts the whole brown-out and power-up delay
// (RULE17) on leaving reset the core fetches from address zero
// (RULE18) other cause flags sit at chosen bits, each set by its source
// (RULE19) async sources are synchronised; release is synchronous, held one cycle minimum
//
// Decided for this implementation: the address map and the plain strobed port.
module src_reset_combiner
(
	// clock and power-on reset
	input wire logic clk,
	input wire logic arst_n,
	// supply detectors and clear pin (asynchronous)
	input wire logic supply_above_poweron,
	input wire logic supply_below_brownout,
	input wire logic clear_pin_reset_n,
	// reset requests from core logic (same clock)
	input wire src_pkg::src_core_req_t core_req,
	// register port
	input wire src_pkg::src_bus_req_t bus_req,
	output logic [15:0] rd_data_q,
	// master reset and core start
	output logic master_reset_q,
	output logic core_start_q,
	output logic [23:0] fetch_addr_q,
	// interrupt
	output logic irq_q
);
	import src_pkg::*;

	// ==========================================================
	// reset release
	logic rst_meta_q;
	logic rst_n_s;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rst_meta_q <= 1'b0;
			rst_n_s <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n_s <= rst_meta_q;
		end
	end

	// ==========================================================
	// input synchronisers
	// bit 2 brown-out low, bit 1 power-on ok, bit 0 clear pin active
	logic [2:0] pin_raw;
	logic [2:0] pin_meta_q;
	logic [2:0] pin_sync_q;
	logic brownout_low_s;
	logic poweron_ok_s;
	logic clear_active_s;

	assign pin_raw = {supply_below_brownout, supply_above_poweron, ~clear_pin_reset_n};

	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			pin_meta_q <= 3'h0;
			pin_sync_q <= 3'h0;
		end
		else
		begin
			pin_meta_q <= pin_raw; // [RULE19]
			pin_sync_q <= pin_meta_q;
		end
	end

	assign brownout_low_s = pin_sync_q[2];
	assign poweron_ok_s = pin_sync_q[1];
	assign clear_active_s = pin_sync_q[0];

	// ==========================================================
	// supply sequencer
	src_state_t state_q;
	logic [CNT_W-1:0] cnt_q;

	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			state_q <= SRC_ST_POWERON_WAIT;
			cnt_q <= '0;
		end
		else if (brownout_low_s)
		begin
			// low supply overrides any delay in progress
			state_q <= SRC_ST_BROWNOUT_LOW; // [RULE12]
			cnt_q <= '0;
		end
		else
		begin
			cnt_q <= cnt_q + 1'b1;
			case (state_q)
				SRC_ST_POWERON_WAIT:
				begin
					cnt_q <= '0;
					if (poweron_ok_s)
					begin
						state_q <= SRC_ST_POWERON_DLY; // [RULE10]
					end
				end
				SRC_ST_POWERON_DLY:
				begin
					if (!poweron_ok_s)
					begin
						state_q <= SRC_ST_POWERON_WAIT;
						cnt_q <= '0;
					end
					else if (cnt_q == CNT_W'(POWERON_SETTLE_CYC - 1))
					begin
						state_q <= SRC_ST_RUN; // [RULE10]
						cnt_q <= '0;
					end
				end
				SRC_ST_BROWNOUT_LOW:
				begin
					// recovery always starts the delay chain from zero
					state_q <= SRC_ST_BROWNOUT_DLY; // [RULE16]
					cnt_q <= '0;
				end
				SRC_ST_BROWNOUT_DLY:
				begin
					if (cnt_q == CNT_W'(BROWNOUT_SETTLE_CYC - 1))
					begin
						state_q <= SRC_ST_POWERUP_DLY; // [RULE13]
						cnt_q <= '0;
					end
				end
				SRC_ST_POWERUP_DLY:
				begin
					if (cnt_q == CNT_W'(POWERUP_SETTLE_CYC - 1))
					begin
						state_q <= SRC_ST_RUN; // [RULE15]
						cnt_q <= '0;
					end
				end
				SRC_ST_RUN:
				begin
					cnt_q <= '0;
				end
				default:
				begin
					state_q <= SRC_ST_POWERON_WAIT;
					cnt_q <= '0;
				end
			endcase
		end
	end

	// ==========================================================
	// source merge and master reset
	logic illegal_any;
	logic any_src;
	logic master_reset_d;

	assign illegal_any = core_req.illegal_opcode | core_req.uninit_wreg
		| core_req.security_violation; // [RULE2]
	assign any_src = clear_active_s | core_req.software_instr_reset
		| core_req.watchdog_timeout_reset | core_req.config_mismatch_reset
		| core_req.trap_conflict_reset | illegal_any; // [RULE2]
	// a low supply holds reset at once, without waiting for the state change
	assign master_reset_d = (state_q != SRC_ST_RUN) | brownout_low_s | any_src; // [RULE1] [RULE3] [RULE12]

	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			master_reset_q <= 1'b1;
		end
		else
		begin
			// registered, so release lands on a clock edge
			master_reset_q <= master_reset_d; // [RULE19]
		end
	end

	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			core_start_q <= 1'b0;
			fetch_addr_q <= RESET_VECTOR;
		end
		else
		begin
			core_start_q <= master_reset_q & ~master_reset_d; // [RULE17]
			if (master_reset_q)
			begin
				fetch_addr_q <= RESET_VECTOR; // [RULE17]
			end
		end
	end

	// ==========================================================
	// reset cause flags
	logic [NUM_CAUSE-1:0] ev_vec;
	logic [NUM_CAUSE-1:0] ev_prev_q;
	logic [NUM_CAUSE-1:0] cause_q;
	logic wr_cause;
	logic wr_stat;
	logic wr_mask;

	assign ev_vec[CAUSE_POWERON] = (state_q == SRC_ST_POWERON_WAIT)
		| (state_q == SRC_ST_POWERON_DLY); // [RULE11]
	assign ev_vec[CAUSE_BROWNOUT] = brownout_low_s; // [RULE14]
	assign ev_vec[CAUSE_CLEAR_PIN] = clear_active_s; // [RULE18]
	assign ev_vec[CAUSE_SOFTWARE] = core_req.software_instr_reset; // [RULE18]
	assign ev_vec[CAUSE_WATCHDOG] = core_req.watchdog_timeout_reset; // [RULE18]
	assign ev_vec[CAUSE_CONFIG] = core_req.config_mismatch_reset; // [RULE18]
	assign ev_vec[CAUSE_TRAP] = core_req.trap_conflict_reset; // [RULE18]
	assign ev_vec[CAUSE_ILLEGAL] = illegal_any; // [RULE18]

	assign wr_cause = bus_req.wr && (bus_req.addr == OFS_CAUSE);
	assign wr_stat = bus_req.wr && (bus_req.addr == OFS_IRQ_STAT);
	assign wr_mask = bus_req.wr && (bus_req.addr == OFS_IRQ_MASK);

	// cause flags survive every reset but power-on
	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			cause_q <= CAUSE_POWERON_RST; // [RULE6] [RULE11]
		end
		else if (wr_cause)
		begin
			// plain store; a live source still wins over the write
			cause_q <= bus_req.wdata[NUM_CAUSE-1:0] | ev_vec; // [RULE7] [RULE8]
		end
		else
		begin
			cause_q <= cause_q | ev_vec; // [RULE5]
		end
	end

	// ==========================================================
	// interrupt status and mask
	logic [NUM_CAUSE-1:0] irq_stat_q;
	logic [NUM_CAUSE-1:0] irq_mask_q;

	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			ev_prev_q <= '0;
		end
		else
		begin
			ev_prev_q <= ev_vec;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CAUSE; gi++)
		begin : g_stat
			always_ff @(posedge clk or negedge rst_n_s)
			begin
				if (!rst_n_s)
				begin
					irq_stat_q[gi] <= 1'b0;
				end
				else if (ev_vec[gi] && !ev_prev_q[gi])
				begin
					irq_stat_q[gi] <= 1'b1;
				end
				else if (wr_stat && bus_req.wdata[gi])
				begin
					irq_stat_q[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// mask is one of the registers a master reset forces
	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			irq_mask_q <= IRQ_MASK_RST;
		end
		else if (master_reset_q)
		begin
			irq_mask_q <= IRQ_MASK_RST; // [RULE4]
		end
		else if (wr_mask)
		begin
			irq_mask_q <= bus_req.wdata[NUM_CAUSE-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			irq_q <= 1'b0;
		end
		else
		begin
			irq_q <= |(irq_stat_q & irq_mask_q);
		end
	end

	// ==========================================================
	// read port
	always_ff @(posedge clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			rd_data_q <= 16'h0000;
		end
		else if (bus_req.rd)
		begin
			case (bus_req.addr)
				OFS_CAUSE: rd_data_q <= {8'h00, cause_q};
				OFS_IRQ_STAT: rd_data_q <= {8'h00, irq_stat_q};
				OFS_IRQ_MASK: rd_data_q <= {8'h00, irq_mask_q};
				default: rd_data_q <= 16'h0000;
			endcase
		end
		else
		begin
			rd_data_q <= 16'h0000;
		end
	end

	// ==========================================================
	// assertions
	AST_SRC_HOLDS: assert property (@(posedge clk) disable iff (!rst_n_s) // [RULE3]
		any_src |=> master_reset_q)
		else $error("source active but master reset low");

	AST_BROWNOUT_HOLD: assert property (@(posedge clk) disable iff (!rst_n_s) // [RULE12]
		brownout_low_s |=> master_reset_q && state_q == SRC_ST_BROWNOUT_LOW)
		else $error("brown-out did not hold reset");

	AST_BROWNOUT_FLAG: assert property (@(posedge clk) disable iff (!rst_n_s) // [RULE14]
		brownout_low_s |=> cause_q[CAUSE_BROWNOUT])
		else $error("brown-out flag not set");

	AST_POWERON_WAIT: assert property (@(posedge clk) disable iff (!rst_n_s) // [RULE10]
		(state_q == SRC_ST_POWERON_WAIT) |=> master_reset_q)
		else $error("reset released before supply good");

	AST_RUN_ENTRY: assert property (@(posedge clk) disable iff (!rst_n_s) // [RULE15]
		(state_q == SRC_ST_RUN) && $changed(state_q) |->
		($past(state_q) == SRC_ST_POWERON_DLY) || ($past(state_q) == SRC_ST_POWERUP_DLY))
		else $error("run entered skipping a delay");

	AST_RESTART: assert property (@(posedge clk) disable iff (!rst_n_s) // [RULE16]
		(state_q == SRC_ST_BROWNOUT_LOW) && !brownout_low_s |=>
		(state_q == SRC_ST_BROWNOUT_DLY) && (cnt_q == '0))
		else $error("delay chain did not restart");

	AST_SW_WRITE: assert property (@(posedge clk) disable iff (!rst_n_s) // [RULE7]
		wr_cause && (ev_vec == '0) |=> cause_q == $past(bus_req.wdata[7:0]))
		else $error("cause write not stored");

	AST_WRITE_NO_RESET: assert property (@(posedge clk) disable iff (!rst_n_s) // [RULE8]
		wr_cause && !master_reset_d |=> !master_reset_q)
		else $error("cause write caused a reset");

	AST_RELEASE: assert property (@(posedge clk) disable iff (!rst_n_s) // [RULE19]
		$fell(master_reset_q) |-> $past(state_q) == SRC_ST_RUN && !$past(any_src))
		else $error("release without clean run state");

	AST_FETCH_ZERO: assert property (@(posedge clk) disable iff (!rst_n_s) // [RULE17]
		$fell(master_reset_q) |-> core_start_q && fetch_addr_q == RESET_VECTOR)
		else $error("core start not at vector zero");

endmodule : src_reset_combiner

// File: bench/src_supply_model.sv
// far-side model: supply detectors and clear pin driven from bench commands
module src_supply_model
#(
	parameter int RAMP = 20
)
(
	// commands from the bench
	input wire logic clk,
	input wire logic power_on,
	input wire logic brown,
	input wire logic clear_press,
	// detector outputs and pin level
	output logic supply_above_poweron,
	output logic supply_below_brownout,
	output logic clear_pin_reset_n
);
	timeunit 1ns;
	timeprecision 1ns;

	int ramp_cnt;

	// ==========================================================
	// detectors are analogue, so levels move well away from the clock edge
	always @(posedge clk)
	begin
		if (!power_on)
			ramp_cnt = 0;
		else if (ramp_cnt < RAMP)
			ramp_cnt++;
		#13;
		supply_above_poweron = power_on && (ramp_cnt >= RAMP);
		supply_below_brownout = brown;
		// the pin has a pull-up, so a released press reads high
		clear_pin_reset_n = !clear_press;
	end

endmodule : src_supply_model

// File: bench/test_system_reset_combiner.sv
// self-checking bench for the system reset combiner
module test_system_reset_combiner;
	timeunit 1ns;
	timeprecision 1ns;
	import src_pkg::*;

	logic clk, arst_n, power_on, brown, clear_press, rd_seen;
	logic supply_above_poweron, supply_below_brownout, clear_pin_reset_n;
	src_core_req_t core_req;
	src_bus_req_t bus_req;
	logic [15:0] rd_data_q;
	logic [15:0] rnd;
	logic [23:0] fetch_addr_q;
	logic master_reset_q, core_start_q, irq_q;
	logic [15:0] exp_q[$];
	int bad_count, comparisons, seed, n, cb;

	src_reset_combiner src_reset_combiner_i (.clk(clk), .arst_n(arst_n),
		.supply_above_poweron(supply_above_poweron), .supply_below_brownout(supply_below_brownout),
		.clear_pin_reset_n(clear_pin_reset_n), .core_req(core_req), .bus_req(bus_req),
		.rd_data_q(rd_data_q), .master_reset_q(master_reset_q), .core_start_q(core_start_q),
		.fetch_addr_q(fetch_addr_q), .irq_q(irq_q));

	src_supply_model #(.RAMP(20)) src_supply_model_i (.clk(clk), .power_on(power_on),
		.brown(brown), .clear_press(clear_press), .supply_above_poweron(supply_above_poweron),
		.supply_below_brownout(supply_below_brownout), .clear_pin_reset_n(clear_pin_reset_n));

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ==========================================================
	// reporting
	task wrong(input string msg);
		$display("wrong value at %0t: %s", $time, msg);
		bad_count++;
	endtask : wrong

	task check_bit(input logic got, input logic exp, input string msg);
		comparisons++;
		if (got !== exp)
			wrong(msg);
	endtask : check_bit

	task wrap_up;
		$display("counts: %0d compared, %0d wrong", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up

	// read data stand one cycle after the strobe: take the oldest note then
	always @(negedge clk)
	begin
		if (rd_seen)
		begin
			comparisons++;
			if (exp_q.size() == 0)
				wrong("read data without a note");
			else if (rd_data_q !== exp_q.pop_front())
				wrong("read data");
		end
		rd_seen = bus_req.rd;
	end

	// ==========================================================
	// bus and wait helpers
	task bus_op(input logic [3:0] a, input logic [15:0] d, input logic w);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
		@(posedge clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
	endtask : bus_op

	task wr(input logic [3:0] a, input logic [15:0] d);
		bus_op(a, d, 1'b1);
	endtask : wr

	task rd(input logic [3:0] a, input logic [15:0] exp);
		exp_q.push_back(exp);
		bus_op(a, 16'h0000, 1'b0);
	endtask : rd

	task settle(input int c);
		repeat (c) @(posedge clk);
		@(negedge clk);
	endtask : settle

	task check_range(input int v, input int lo, input int hi, input string msg);
		check_bit(v >= lo && v <= hi, 1'b1, msg);
	endtask : check_range

	// bounded wait for release; start pulse belongs to the first low cycle
	task wait_run(output int cnt);
		cnt = 0;
		while (master_reset_q !== 1'b0 && cnt < 3000)
		begin
			@(negedge clk);
			cnt++;
		end
		check_bit(core_start_q, 1'b1, "no start pulse");
		check_bit(fetch_addr_q === 24'h000000, 1'b1, "fetch address");
	endtask : wait_run

	task power_reset;
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
	endtask : power_reset

	// ==========================================================
	// tests
	initial
	begin
		seed = 59139;
		bad_count = 0;
		comparisons = 0;
		arst_n = 1'b0;
		power_on = 1'b0;
		brown = 1'b0;
		clear_press = 1'b0;
		core_req = '0;
		bus_req = '0;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(OFS_CAUSE, 16'h0001);
		settle(50);
		check_bit(master_reset_q, 1'b1, "released without supply");
		@(posedge clk);
		power_on <= 1'b1;
		settle(21);
		wait_run(n);
		check_range(n, 200, 206, "power-on settle");
		$display("test power-on done");

		rnd = 16'($random(seed));
		wr(OFS_CAUSE, rnd);
		rd(OFS_CAUSE, {8'h00, rnd[7:0]});
		wr(OFS_CAUSE, 16'h00ff);
		settle(2);
		check_bit(master_reset_q, 1'b0, "flag write caused reset");
		wr(OFS_CAUSE, 16'h0000);
		rd(OFS_CAUSE, 16'h0000);
		wr(4'hc, 16'hffff);
		rd(4'hc, 16'h0000);
		rd(OFS_CAUSE, 16'h0000);
		wr(OFS_IRQ_STAT, 16'h00ff);
		$display("test software flags done");

		// seven core requests, then the clear pin as the eighth source
		for (int i = 0; i < 8; i++)
		begin
			cb = (i < 4) ? 3 + i : (i < 7) ? 7 : 2;
			@(posedge clk);
			if (i == 7)
				clear_press <= 1'b1;
			else
				core_req <= src_core_req_t'(7'h40 >> i);
			settle(4);
			check_bit(master_reset_q, 1'b1, "source without reset");
			@(posedge clk);
			core_req <= '0;
			clear_press <= 1'b0;
			@(negedge clk);
			wait_run(n);
			check_bit(irq_q, 1'b0, "mask survived reset");
			rd(OFS_CAUSE, 16'h0001 << cb);
			wr(OFS_IRQ_MASK, 16'h00ff);
			settle(2);
			check_bit(irq_q, 1'b1, "irq not raised");
			wr(OFS_IRQ_STAT, 16'h00ff);
			settle(2);
			check_bit(irq_q, 1'b0, "irq not cleared");
			wr(OFS_CAUSE, 16'h0000);
		end
		$display("test reset sources done");

		@(posedge clk);
		brown <= 1'b1;
		settle(5);
		check_bit(master_reset_q, 1'b1, "no brown-out reset");
		rd(OFS_CAUSE, 16'h0002);
		@(posedge clk);
		brown <= 1'b0;
		settle(100);
		check_bit(master_reset_q, 1'b1, "brown-out released early");
		@(posedge clk);
		brown <= 1'b1;
		settle(5);
		@(posedge clk);
		brown <= 1'b0;
		@(negedge clk);
		wait_run(n);
		check_range(n, 1480, 1495, "brown-out plus power-up delay");
		$display("test brown-out done");

		wr(OFS_CAUSE, 16'h00fe);
		power_reset();
		rd(OFS_CAUSE, 16'h0001);
		@(negedge clk);
		wait_run(n);
		check_range(n, 190, 206, "second power-on settle");
		$display("test second power-on done");
		wrap_up();
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		wrong("timeout");
		wrap_up();
	end

endmodule : test_system_reset_combiner
